// file: verilog/crwsc_top.sv
// register bank and rate decode for the capture resizer window and scaling rates
// Notes on behaviour
// - end column is an 11-bit field in bits 10..0, rightmost processed column
// - end row is an 11-bit field in bits 10..0; bits 15..11 unused
// - end row register is read/write and resets to 01DFh, line 479
// - rate register is 16-bit read/write: vertical code high byte, horizontal low byte
// - vertical code in high byte applies only when independent scaling is on
// - in modes 01b and 10b vertical code n in 1..128 gives n/128
// - with independent scaling off, low byte code sets both directions
// - horizontal: mode 01b any 1..128; mode 10b powers of two only
// - with vsync update on, old values stay in use until next vsync
`timescale 1ns/1ps
`default_nettype none
module crwsc_top (
    input wire logic core_clk, // 40 MHz system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic [15:0] reg_addr, // register byte address
    input wire logic [15:0] reg_wdata, // register write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [15:0] reg_rdata, // read data, cycle after the strobe
    input wire logic vsync, // one-cycle vertical sync pulse from capture timing
    output logic resizer_en, // resizer enable in use
    output logic [10:0] use_end_col, // end column in use
    output logic [10:0] use_end_row, // end row in use
    output logic [7:0] h_num, // horizontal ratio numerator over 128
    output logic [7:0] v_num, // vertical ratio numerator over 128
    output logic h_ok, // horizontal code legal
    output logic v_ok, // vertical code legal
    output logic [11:0] out_rows // lines delivered for the window height
);
    import crwsc_pkg::*;

    logic [10:0] end_col_ff; // programmed values
    logic [10:0] end_row_ff;
    logic [15:0] rates_ff;
    logic [2:0] ctrl_ff;
    crwsc_mode_t mode_ff;
    logic [10:0] act_end_col_ff; // values in use by the resizer
    logic [10:0] act_end_row_ff;
    logic [15:0] act_rates_ff;
    logic [2:0] act_ctrl_ff;
    crwsc_mode_t act_mode_ff;
    logic [15:0] nxt_rdata;
    logic [15:0] rdata_ff;
    logic take_new;
    logic [7:0] v_code;
    logic [7:0] h_num_c;
    logic [7:0] v_num_c;
    logic h_ok_c;
    logic v_ok_c;
    logic [7:0] h_num_ff;
    logic [7:0] v_num_ff;
    logic h_ok_ff;
    logic v_ok_ff;
    logic [19:0] rows_prod;
    logic [11:0] nxt_out_rows;
    logic [11:0] out_rows_ff;

    // window corner registers, unused upper bits are not stored
    always_ff @(posedge core_clk) begin
        if (rst) begin
            end_col_ff <= CRWSC_RST_END_COL;
            end_row_ff <= CRWSC_RST_END_ROW;
        end else if (reg_wr) begin
            if (reg_addr == CRWSC_ADDR_END_COL) begin
                end_col_ff <= reg_wdata[CRWSC_POS_W-1:0];
            end
            if (reg_addr == CRWSC_ADDR_END_ROW) begin
                end_row_ff <= reg_wdata[CRWSC_POS_W-1:0];
            end
        end
    end

    // scaling rate, control and mode registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rates_ff <= CRWSC_RST_RATES;
            ctrl_ff <= CRWSC_RST_CTRL;
            mode_ff <= CRWSC_MODE_NONE;
        end else if (reg_wr) begin
            if (reg_addr == CRWSC_ADDR_RATES) begin
                rates_ff <= reg_wdata;
            end
            if (reg_addr == CRWSC_ADDR_CTRL) begin
                ctrl_ff <= reg_wdata[2:0];
            end
            if (reg_addr == CRWSC_ADDR_MODE) begin
                mode_ff <= crwsc_mode_t'(reg_wdata[1:0]);
            end
        end
    end

    // read mux, reserved bits and unmapped addresses read zero
    always_comb begin
        nxt_rdata = 16'h0000;
        unique case (reg_addr)
            CRWSC_ADDR_END_COL: nxt_rdata = {5'h00, end_col_ff};
            CRWSC_ADDR_END_ROW: nxt_rdata = {5'h00, end_row_ff};
            CRWSC_ADDR_RATES: nxt_rdata = rates_ff;
            CRWSC_ADDR_CTRL: nxt_rdata = {13'h0000, ctrl_ff};
            CRWSC_ADDR_MODE: nxt_rdata = {14'h0000, mode_ff};
            default: nxt_rdata = 16'h0000;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_ff <= 16'h0000;
        end else begin
            rdata_ff <= reg_rd ? nxt_rdata : 16'h0000;
        end
    end
    assign reg_rdata = rdata_ff;

    // shadow copies: follow at once, or only on vsync when deferred update is on
    assign take_new = !ctrl_ff[CRWSC_CTRL_UPD_VSYNC] || vsync;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            act_end_col_ff <= CRWSC_RST_END_COL;
            act_end_row_ff <= CRWSC_RST_END_ROW;
            act_rates_ff <= CRWSC_RST_RATES;
            act_ctrl_ff <= CRWSC_RST_CTRL;
            act_mode_ff <= CRWSC_MODE_NONE;
        end else if (take_new) begin
            act_end_col_ff <= end_col_ff;
            act_end_row_ff <= end_row_ff;
            act_rates_ff <= rates_ff;
            act_ctrl_ff <= ctrl_ff;
            act_mode_ff <= mode_ff;
        end
    end

    // vertical code: high byte when independent, else the shared low byte
    assign v_code = act_ctrl_ff[CRWSC_CTRL_INDEP] ?
        act_rates_ff[CRWSC_V_CODE_HI:CRWSC_V_CODE_LO] :
        act_rates_ff[CRWSC_H_CODE_HI:CRWSC_H_CODE_LO];

    crwsc_rate_decode #(.POW2_IN_COARSE(1'b1)) u_h_dec (
        .code(act_rates_ff[CRWSC_H_CODE_HI:CRWSC_H_CODE_LO]),
        .mode(act_mode_ff),
        .num(h_num_c),
        .ok(h_ok_c)
    );

    crwsc_rate_decode #(.POW2_IN_COARSE(1'b0)) u_v_dec (
        .code(v_code),
        .mode(act_mode_ff),
        .num(v_num_c),
        .ok(v_ok_c)
    );

    // output lines = window height * n / 128, truncated
    // widen before the add so that a height of 2048 lines does not wrap to zero
    assign rows_prod = (20'(act_end_row_ff) + 20'h00001) * 20'(v_num_c);
    assign nxt_out_rows = rows_prod[CRWSC_RATE_SHIFT +: 12];

    // registered decode results
    always_ff @(posedge core_clk) begin
        if (rst) begin
            h_num_ff <= 8'h00;
            v_num_ff <= 8'h00;
            h_ok_ff <= 1'b0;
            v_ok_ff <= 1'b0;
            out_rows_ff <= 12'h000;
        end else begin
            h_num_ff <= h_num_c;
            v_num_ff <= v_num_c;
            h_ok_ff <= h_ok_c;
            v_ok_ff <= v_ok_c;
            out_rows_ff <= nxt_out_rows;
        end
    end

    assign resizer_en = act_ctrl_ff[CRWSC_CTRL_EN];
    assign use_end_col = act_end_col_ff;
    assign use_end_row = act_end_row_ff;
    assign h_num = h_num_ff;
    assign v_num = v_num_ff;
    assign h_ok = h_ok_ff;
    assign v_ok = v_ok_ff;
    assign out_rows = out_rows_ff;

    // checks on register access, shadowing and decode
    a_end_col_write: assert property (@(posedge core_clk) disable iff (rst)
        reg_wr && reg_addr == CRWSC_ADDR_END_COL |=> end_col_ff == $past(reg_wdata[10:0]))
        else $error("end column write not stored");
    a_end_row_reset: assert property (@(posedge core_clk)
        rst ##1 !rst && !reg_rd |=> reg_rdata == 16'h0000 ##0 end_row_ff == 11'h1DF)
        else $error("end row reset value wrong");
    a_row_read_back: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == CRWSC_ADDR_END_ROW |=> reg_rdata[15:11] == 5'h00
        && reg_rdata[10:0] == end_row_ff)
        else $error("end row readback wrong");
    a_rates_read_back: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == CRWSC_ADDR_RATES |=> reg_rdata == rates_ff)
        else $error("rate register readback wrong");
    a_vsync_hold: assert property (@(posedge core_clk) disable iff (rst)
        ctrl_ff[CRWSC_CTRL_UPD_VSYNC] && !vsync |=> $stable(act_rates_ff)
        && $stable(act_end_row_ff))
        else $error("values in use changed before vsync");
    a_immediate_take: assert property (@(posedge core_clk) disable iff (rst)
        !ctrl_ff[CRWSC_CTRL_UPD_VSYNC] && reg_wr && reg_addr == CRWSC_ADDR_RATES
        && $past(!ctrl_ff[CRWSC_CTRL_UPD_VSYNC]) |=> ##1 act_rates_ff == $past(reg_wdata, 2))
        else $error("immediate update not taken");
    a_v_sel_shared: assert property (@(posedge core_clk) disable iff (rst)
        !act_ctrl_ff[CRWSC_CTRL_INDEP] && act_mode_ff == CRWSC_MODE_FINE
        && act_rates_ff[7:0] != 8'h00 && act_rates_ff[7:0] <= 8'h80
        |=> v_num_ff == $past(act_rates_ff[7:0]))
        else $error("shared vertical code not used");
    a_v_sel_indep: assert property (@(posedge core_clk) disable iff (rst)
        act_ctrl_ff[CRWSC_CTRL_INDEP] && act_mode_ff == CRWSC_MODE_COARSE
        && act_rates_ff[15:8] == 8'h03 |=> v_num_ff == 8'h03 && v_ok_ff)
        else $error("independent vertical code not decoded");
    a_h_pow2_only: assert property (@(posedge core_clk) disable iff (rst)
        act_mode_ff == CRWSC_MODE_COARSE && act_rates_ff[7:0] == 8'h03
        |=> !h_ok_ff && h_num_ff == 8'h00)
        else $error("coarse mode accepted non power of two");
    a_unity_rows: assert property (@(posedge core_clk) disable iff (rst)
        v_ok_c && v_num_c == 8'h80 |=> out_rows_ff == 12'($past(act_end_row_ff)) + 12'h001)
        else $error("unity ratio did not pass all lines");

    c_deferred_update: cover property (@(posedge core_clk) disable iff (rst)
        ctrl_ff[CRWSC_CTRL_UPD_VSYNC] && vsync && rates_ff != act_rates_ff);
    c_indep_scaling: cover property (@(posedge core_clk) disable iff (rst)
        v_ok_ff && h_ok_ff && v_num_ff != h_num_ff);
    c_reduced_rows: cover property (@(posedge core_clk) disable iff (rst)
        v_ok_ff && v_num_ff < 8'h80 && out_rows_ff != 12'h000);
endmodule
`default_nettype wire

// file: verilog/crwsc_pkg.sv
// constants and types for the capture resizer window and scale configuration block
package crwsc_pkg;
    // register byte addresses on the 16-bit register port
    localparam logic [15:0] CRWSC_ADDR_CTRL = 16'h2460;
    localparam logic [15:0] CRWSC_ADDR_END_COL = 16'h2468;
    localparam logic [15:0] CRWSC_ADDR_END_ROW = 16'h246A;
    localparam logic [15:0] CRWSC_ADDR_RATES = 16'h246C;
    localparam logic [15:0] CRWSC_ADDR_MODE = 16'h246E;
    // reset values
    localparam logic [10:0] CRWSC_RST_END_COL = 11'h27F;
    localparam logic [10:0] CRWSC_RST_END_ROW = 11'h1DF;
    localparam logic [15:0] CRWSC_RST_RATES = 16'h8080;
    localparam logic [2:0] CRWSC_RST_CTRL = 3'h0;
    // field layout
    localparam int CRWSC_POS_W = 11;
    localparam int CRWSC_CTRL_EN = 0;
    localparam int CRWSC_CTRL_UPD_VSYNC = 1;
    localparam int CRWSC_CTRL_INDEP = 2;
    localparam int CRWSC_V_CODE_HI = 15;
    localparam int CRWSC_V_CODE_LO = 8;
    localparam int CRWSC_H_CODE_HI = 7;
    localparam int CRWSC_H_CODE_LO = 0;
    // rate arithmetic: ratio is code / 128
    localparam logic [7:0] CRWSC_RATE_UNITY = 8'h80;
    localparam int CRWSC_RATE_SHIFT = 7;
    // scaling mode codes
    typedef enum logic [1:0] {
        CRWSC_MODE_NONE = 2'h0,
        CRWSC_MODE_FINE = 2'h1,
        CRWSC_MODE_COARSE = 2'h2,
        CRWSC_MODE_RSVD = 2'h3
    } crwsc_mode_t;
endpackage

// file: verilog/crwsc_rate_decode.sv
// decodes one 8-bit scaling rate code into an n/128 numerator and a valid flag
`timescale 1ns/1ps
`default_nettype none
module crwsc_rate_decode #(
    parameter bit POW2_IN_COARSE = 1'b0 // coarse mode accepts only powers of two
) (
    input wire logic [7:0] code, // rate code n
    input wire crwsc_pkg::crwsc_mode_t mode, // scaling mode
    output logic [7:0] num, // numerator of n/128, zero when invalid
    output logic ok // code is legal in this mode
);
    import crwsc_pkg::*;

    logic in_range;
    logic pow2;

    // code 0 and codes above 128 never select a ratio
    assign in_range = (code != 8'h00) && (code <= CRWSC_RATE_UNITY);
    assign pow2 = ((code & (code - 8'h01)) == 8'h00);

    // legality per mode, none and reserved modes select nothing
    always_comb begin
        unique case (mode)
            CRWSC_MODE_FINE: ok = in_range;
            CRWSC_MODE_COARSE: ok = in_range && (!POW2_IN_COARSE || pow2);
            CRWSC_MODE_NONE: ok = 1'b0;
            CRWSC_MODE_RSVD: ok = 1'b0;
        endcase
    end

    assign num = ok ? code : 8'h00;
endmodule
`default_nettype wire

// file: bench/crwsc_top_tb_top.sv
// self-checking testbench for the capture resizer window and scaling rate registers
`timescale 1ns/1ps
`default_nettype none
module crwsc_top_tb_top;
    import crwsc_pkg::*;
    typedef struct packed {
        crwsc_mode_t mode;
        logic [2:0] ctrl;
        logic [15:0] rates;
        logic [7:0] h;
        logic [7:0] v;
        logic hok;
        logic vok;
    } crwsc_row_t;
    logic core_clk, rst, reg_wr, reg_rd, vsync, resizer_en, h_ok, v_ok;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [10:0] use_end_col, use_end_row;
    logic [7:0] h_num, v_num;
    logic [11:0] out_rows;
    logic [19:0] t;
    int n_fail = 0;
    int n_compared = 0;
    crwsc_row_t rows [9];
    crwsc_top dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vsync(vsync),
        .resizer_en(resizer_en), .use_end_col(use_end_col), .use_end_row(use_end_row),
        .h_num(h_num), .v_num(v_num), .h_ok(h_ok), .v_ok(v_ok), .out_rows(out_rows));
    // 40 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // compare one value and count it
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    // one-cycle register write
    task automatic wr(input logic [15:0] a, input logic [15:0] w);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= w;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // one-cycle register read, data taken in the following cycle
    task automatic rd(input logic [15:0] a, output logic [15:0] r);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 r = reg_rdata;
    endtask
    // settle for a number of cycles, then step past the edge
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        #(3000 * 25);
        n_fail++;
        final_report();
    end
    // main sequence
    initial begin
        rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; vsync = 1'b0;
        reg_addr = 16'h0000; reg_wdata = 16'h0000;
        rows = '{'{CRWSC_MODE_FINE, 3'h5, 16'h4003, 8'h03, 8'h40, 1'b1, 1'b1},
            '{CRWSC_MODE_COARSE, 3'h4, 16'h0304, 8'h04, 8'h03, 1'b1, 1'b1},
            '{CRWSC_MODE_COARSE, 3'h5, 16'h0403, 8'h00, 8'h04, 1'b0, 1'b1},
            '{CRWSC_MODE_FINE, 3'h1, 16'h0510, 8'h10, 8'h10, 1'b1, 1'b1},
            '{CRWSC_MODE_COARSE, 3'h0, 16'h2003, 8'h00, 8'h03, 1'b0, 1'b1},
            '{CRWSC_MODE_NONE, 3'h4, 16'h8080, 8'h00, 8'h00, 1'b0, 1'b0},
            '{CRWSC_MODE_RSVD, 3'h4, 16'h8080, 8'h00, 8'h00, 1'b0, 1'b0},
            '{CRWSC_MODE_FINE, 3'h4, 16'h8180, 8'h80, 8'h00, 1'b1, 1'b0},
            '{CRWSC_MODE_FINE, 3'h4, 16'h0100, 8'h00, 8'h01, 1'b0, 1'b1}};
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        // reset values
        idle(1);
        check(use_end_row, 16'h01DF);
        rd(CRWSC_ADDR_END_ROW, d);
        check(d, 16'h01DF);
        idle(1);
        check(reg_rdata, 16'h0000);
        rd(CRWSC_ADDR_RATES, d);
        check(d, CRWSC_RST_RATES);
        rd(CRWSC_ADDR_END_COL, d);
        check(d, 16'h027F);
        $display("reset values done");
        // rate decode table; rows seven, eight and nine hold codes software may not set
        foreach (rows[i]) begin
            wr(CRWSC_ADDR_MODE, {14'h0000, rows[i].mode});
            wr(CRWSC_ADDR_CTRL, {13'h0000, rows[i].ctrl});
            wr(CRWSC_ADDR_RATES, rows[i].rates);
            idle(4);
            t = (20'(CRWSC_RST_END_ROW) + 20'h00001) * 20'(rows[i].v);
            check(h_num, rows[i].h);
            check(h_ok, rows[i].hok);
            check(v_num, rows[i].v);
            check(v_ok, rows[i].vok);
            check(out_rows, t[18:7]);
            check(resizer_en, rows[i].ctrl[0]);
            rd(CRWSC_ADDR_RATES, d);
            check(d, rows[i].rates);
        end
        $display("rate table done");
        // deferred update: old corners stay until vsync, unused row bits dropped
        wr(CRWSC_ADDR_CTRL, 16'h0003);
        wr(CRWSC_ADDR_END_COL, 16'h0123); // even width, within resizer limits
        wr(CRWSC_ADDR_END_ROW, 16'hFFFF);
        wr(CRWSC_ADDR_RATES, 16'h0080);
        idle(4);
        check(use_end_col, 16'h027F);
        check(use_end_row, 16'h01DF);
        check(h_num, 16'h0000);
        rd(CRWSC_ADDR_END_ROW, d);
        check(d, 16'h07FF);
        @(posedge core_clk);
        vsync <= 1'b1;
        @(posedge core_clk);
        vsync <= 1'b0;
        idle(2);
        check(use_end_col, 16'h0123);
        check(use_end_row, 16'h07FF);
        check(h_num, 16'h0080);
        check(v_num, 16'h0080);
        check(out_rows, 16'h0800);
        rd(CRWSC_ADDR_END_COL, d);
        check(d, 16'h0123);
        $display("deferred update done");
        // unmapped address reads zero
        wr(16'h2462, 16'h5A5A);
        rd(16'h2462, d);
        check(d, 16'h0000);
        $display("unmapped access done");
        // second reset in mid-run restores the end row
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        rd(CRWSC_ADDR_END_ROW, d);
        check(d, 16'h01DF);
        check(use_end_row, 16'h01DF);
        check(use_end_col, 16'h027F);
        check(h_num, 16'h0000);
        check(out_rows, 16'h0000);
        $display("second reset done");
        final_report();
    end
endmodule
`default_nettype wire
